// *** hw/prss_top.sv ***
// Self-supervision core: fault collection, failure output, indicators, auto-config
module prss_top
  import prss_pkg::*;
#(
  parameter int HOLD = HOLD_CYC,
  parameter int BLINK = BLINK_CYC,
  parameter int SYNC_PERIOD = SYNC_CYC,
  parameter int NS = NUM_SENS,
  parameter int NB = NUM_BIN,
  parameter int NW = NUM_SW,
  parameter int CW = CUR_W
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic SUPPLY_OK,
  input wire logic HW_FAULT,
  input wire logic SW_FAULT,
  input wire logic [NS-1:0] SENSOR_PRESENT,
  input wire logic [NS-1:0] SENSOR_FAULT,
  input wire logic [NS-1:0] SENSOR_LIGHT,
  input wire logic [NB-1:0] BIN_CONNECTED,
  input wire logic [NW-1:0] SWITCHES,
  input wire logic SET_BUTTON,
  input wire logic [CW-1:0] PHASE_CURRENT_A,
  input wire logic [CW-1:0] PHASE_CURRENT_B,
  input wire logic [CW-1:0] PHASE_CURRENT_C,
  input wire logic [CW-1:0] NOMINAL_CURRENT,
  input wire logic FAST_OUTPUT_TWO_REQ,
  output logic SYSTEM_FAIL_OUTPUT,
  output logic POWER_LED,
  output logic ERROR_LED,
  output logic [NS-1:0] SENSOR_LED,
  output logic [NUM_PH-1:0] PHASE_LED,
  output logic [NS-1:0] SENSOR_ENABLE,
  output logic [NW-1:0] ACTIVE_SWITCHES,
  output logic [NS-1:0] STORED_SENSORS,
  output logic [NB-1:0] STORED_BINARY,
  output logic SETTINGS_ALARM,
  output logic OPEN_CT_ALARM,
  output logic ENERGIZED,
  output logic FAST_OUTPUT_TWO
);
  localparam int BW = $clog2(BLINK + 1);
  localparam int YW = $clog2(SYNC_PERIOD + 1);

  // ----------------------------------------
  // Stored configuration and settings alarm
  // ----------------------------------------
  logic [NS-1:0] ref_sens_q;
  logic [NB-1:0] ref_bin_q;
  logic [NW-1:0] ref_sw_q;
  logic cfg_alarm_q;
  logic cfg_alarm_d;
  logic [NS-1:0] ref_sens_d;
  logic [NB-1:0] ref_bin_d;
  logic [NW-1:0] ref_sw_d;
  logic hold_fire;

  prss_button #(.HOLD(HOLD)) u_button (
    .clock(CLOCK),
    .rstn(RSTN),
    .ce(CE),
    .pressed(SET_BUTTON),
    .fire(hold_fire)
  );

  wire sw_mismatch = (SWITCHES != ref_sw_q);

  always_comb begin
    ref_sens_d = ref_sens_q;
    ref_bin_d = ref_bin_q;
    ref_sw_d = ref_sw_q;
    cfg_alarm_d = cfg_alarm_q;
    // Mismatch latches alarm; stored settings kept
    if (sw_mismatch) begin
      cfg_alarm_d = 1'b1;
    end
    // Hold stores sensors, inputs and switches
    if (hold_fire) begin
      ref_sens_d = SENSOR_PRESENT;
      ref_bin_d = BIN_CONNECTED;
      ref_sw_d = SWITCHES;
      // Alarm cleared only by a full hold
      cfg_alarm_d = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      ref_sens_q <= '0;
      ref_bin_q <= '0;
      ref_sw_q <= '0;
      cfg_alarm_q <= 1'b0;
    end else if (CE) begin
      ref_sens_q <= ref_sens_d;
      ref_bin_q <= ref_bin_d;
      ref_sw_q <= ref_sw_d;
      cfg_alarm_q <= cfg_alarm_d;
    end
  end

  // ----------------------------------------
  // Fault sources
  // ----------------------------------------
  logic ct_energized;
  logic ct_open;
  prss_opent #(.W(CW)) u_opent (
    .cur_a(PHASE_CURRENT_A),
    .cur_b(PHASE_CURRENT_B),
    .cur_c(PHASE_CURRENT_C),
    .nominal(NOMINAL_CURRENT),
    .energized(ct_energized),
    .open_alarm(ct_open)
  );

  wire [NS-1:0] sens_bad = ref_sens_q & (SENSOR_FAULT | ~SENSOR_PRESENT);
  wire [NS-1:0] sens_new = SENSOR_PRESENT & ~ref_sens_q;
  wire bin_bad = |(ref_bin_q & ~BIN_CONNECTED);
  // Error stays while any stored sensor missing
  wire sens_err = |(sens_bad | sens_new);
  // Any active source keeps output released
  wire any_fault = !SUPPLY_OK || HW_FAULT || SW_FAULT || bin_bad || sens_err ||
                   cfg_alarm_q || ct_open;

  // ----------------------------------------
  // Failure output and indicators
  // ----------------------------------------
  logic fail_q;
  logic [BW-1:0] blink_cnt_q;
  logic blink_q;
  wire blink_wrap = (blink_cnt_q == BW'(BLINK - 1));

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      fail_q <= 1'b1;
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (CE) begin
      fail_q <= any_fault;
      blink_cnt_q <= blink_wrap ? '0 : blink_cnt_q + BW'(1);
      blink_q <= blink_wrap ? ~blink_q : blink_q;
    end
  end

  assign POWER_LED = SUPPLY_OK;
  // Clears by itself when cause gone, except the latched settings alarm
  assign SYSTEM_FAIL_OUTPUT = !fail_q;
  assign ERROR_LED = fail_q;
  // Blink faulty or new channel, follow SENSOR_LIGHT otherwise
  assign SENSOR_LED = ({NS{blink_q}} & (sens_bad | sens_new)) |
                      (SENSOR_LIGHT & ~(sens_bad | sens_new));
  // Blink phase indicators on open transformer
  assign PHASE_LED = {NUM_PH{blink_q & ct_open}};
  assign SENSOR_ENABLE = ref_sens_q & SENSOR_PRESENT & ~SENSOR_FAULT;
  assign ACTIVE_SWITCHES = ref_sw_q;
  assign STORED_SENSORS = ref_sens_q;
  assign STORED_BINARY = ref_bin_q;
  assign SETTINGS_ALARM = cfg_alarm_q;
  assign OPEN_CT_ALARM = ct_open;
  assign ENERGIZED = ct_energized;

  // ----------------------------------------
  // Sync pulse on second fast output
  // ----------------------------------------
  // Sync is a short pulse while idle; an active request always wins so trips are never cut
  logic [YW-1:0] sync_cnt_q;
  logic fast2_q;
  wire sync_wrap = (sync_cnt_q == YW'(SYNC_PERIOD - 1));
  wire sync_hit = (sync_cnt_q < YW'(SYNC_PULSE_CYC));

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      sync_cnt_q <= '0;
      fast2_q <= 1'b0;
    end else if (CE) begin
      sync_cnt_q <= sync_wrap ? '0 : sync_cnt_q + YW'(1);
      fast2_q <= FAST_OUTPUT_TWO_REQ | sync_hit;
    end
  end
  assign FAST_OUTPUT_TWO = fast2_q;
endmodule

// *** hw/prss_pkg.sv ***
// Constants and types for the protection relay self-supervision block
// Operation
// - The block continuously watches supply, hardware, software, binary input wiring and sensors, and compares live switches with the stored setup.
// - With no fault present the power indicator is lit and the system-failure output is energized.
// - Any supervised fault or supply failure releases the system-failure output and lights the error indicator.
// - A failed sensor channel puts the block in error mode, blinks its indicator and blocks only that channel.
// - When a sensor fault goes away the failure status clears by itself, re-energizing the output and darkening the error indicator.
// - Disconnected sensors keep the block in error mode until restored while connected sensors stay in use.
// - A switch setting that differs from the stored setup raises a failure alarm while the stored settings stay in force.
// - A settings-mismatch alarm clears only after the set button is held continuously for two seconds.
// - A two-second hold starts auto-configuration, storing the connected sensors and binary input lines as reference.
// - A newly connected sensor not in the stored setup lights the error indicator and blinks its channel indicator.
// - Current above 0.2 times nominal marks the switchgear energized and enables open transformer supervision.
// - One or two phases at zero while the others stay above 0.2 times nominal raise an open transformer alarm.
// - An open transformer alarm releases the failure output, lights the error indicator and blinks the phase indicators.
// - The failure output stays released until the block is healthy again and only then re-energizes.
// - The second fast output also carries a sync pulse for remote light relays without disturbing its other use.
package prss_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int HOLD_MS = 2000;
  localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
  localparam int BLINK_MS = 250;
  localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
  localparam int SYNC_MS = 10;
  localparam int SYNC_CYC = SYNC_MS * 1000 * CLK_MHZ;
  localparam int SYNC_PULSE_CYC = 1;
  // ----------------------------------------
  // Sizes and thresholds
  // ----------------------------------------
  localparam int NUM_SENS = 4;
  localparam int NUM_BIN = 2;
  localparam int NUM_SW = 16;
  localparam int NUM_PH = 3;
  localparam int CUR_W = 16;
  // Threshold is 0.2 x nominal: compare 5*I against nominal
  localparam int THR_MUL = 5;
  localparam logic [CUR_W-1:0] CUR_ZERO = 16'h0000;
  typedef enum logic [1:0] {PRSS_IDLE, PRSS_TIMING, PRSS_DONE} prss_btn_t;
endpackage

// *** hw/prss_button.sv ***
// Set button hold timer: one pulse per continuous press reaching the hold time
module prss_button
  import prss_pkg::*;
#(
  parameter int HOLD = HOLD_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pressed,
  output logic fire
);
  localparam int CW = $clog2(HOLD + 1);
  prss_btn_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  wire at_end = (cnt_q == CW'(HOLD - 1));

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    fire = 1'b0;
    unique case (st_q)
      PRSS_IDLE: begin
        cnt_d = '0;
        if (pressed) begin
          st_d = PRSS_TIMING;
        end
      end
      PRSS_TIMING: begin
        if (!pressed) begin
          st_d = PRSS_IDLE;
        end else if (at_end) begin
          st_d = PRSS_DONE;
          fire = ce;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      PRSS_DONE: begin
        if (!pressed) begin
          st_d = PRSS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      st_q <= PRSS_IDLE;
      cnt_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// *** hw/prss_opent.sv ***
// Open current transformer check on the three phase currents
module prss_opent
  import prss_pkg::*;
#(
  parameter int W = CUR_W
) (
  input wire logic [W-1:0] cur_a,
  input wire logic [W-1:0] cur_b,
  input wire logic [W-1:0] cur_c,
  input wire logic [W-1:0] nominal,
  output logic energized,
  output logic open_alarm
);
  localparam int PW = W + 3;
  logic [NUM_PH-1:0] above, zero;
  always_comb begin
    above[0] = (PW'(cur_a) * PW'(THR_MUL)) > PW'(nominal);
    above[1] = (PW'(cur_b) * PW'(THR_MUL)) > PW'(nominal);
    above[2] = (PW'(cur_c) * PW'(THR_MUL)) > PW'(nominal);
    zero[0] = (cur_a == W'(CUR_ZERO));
    zero[1] = (cur_b == W'(CUR_ZERO));
    zero[2] = (cur_c == W'(CUR_ZERO));
  end
  assign energized = |above;
  // Some phases zero, all others above
  assign open_alarm = energized && (|zero) && ((zero | above) == {NUM_PH{1'b1}});
endmodule

// *** test/prss_top_assertions.sv ***
// Port-level checker for the self-supervision core
module prss_top_assertions
  import prss_pkg::*;
#(
  parameter int NS = NUM_SENS,
  parameter int CW = CUR_W
) (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic SUPPLY_OK,
  input wire logic HW_FAULT,
  input wire logic SW_FAULT,
  input wire logic [NS-1:0] SENSOR_PRESENT,
  input wire logic [NS-1:0] SENSOR_FAULT,
  input wire logic SET_BUTTON,
  input wire logic [CW-1:0] PHASE_CURRENT_A,
  input wire logic [CW-1:0] PHASE_CURRENT_B,
  input wire logic [CW-1:0] PHASE_CURRENT_C,
  input wire logic [CW-1:0] NOMINAL_CURRENT,
  input wire logic SYSTEM_FAIL_OUTPUT,
  input wire logic ERROR_LED,
  input wire logic [NS-1:0] SENSOR_ENABLE,
  input wire logic [NS-1:0] STORED_SENSORS,
  input wire logic SETTINGS_ALARM,
  input wire logic OPEN_CT_ALARM
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NUM_PH-1:0] above;
  logic [NUM_PH-1:0] zero;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Phase above 0.2 x nominal, done as 5*I against nominal to avoid fractions
  assign above = {THR_MUL * PHASE_CURRENT_C > NOMINAL_CURRENT,
    THR_MUL * PHASE_CURRENT_B > NOMINAL_CURRENT, THR_MUL * PHASE_CURRENT_A > NOMINAL_CURRENT};
  assign zero = {PHASE_CURRENT_C == CUR_ZERO, PHASE_CURRENT_B == CUR_ZERO,
    PHASE_CURRENT_A == CUR_ZERO};
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_alarm_drop; $fell(SETTINGS_ALARM); endsequence
  property p_sup; CE && !SUPPLY_OK |-> ##1 (!SYSTEM_FAIL_OUTPUT && ERROR_LED); endproperty
  a_sup: assert property (p_sup) else $error("supply loss not flagged");
  property p_fault; CE && (HW_FAULT || SW_FAULT) |=> !SYSTEM_FAIL_OUTPUT; endproperty
  a_fault: assert property (p_fault) else $error("internal fault not flagged");
  property p_bad; CE && (STORED_SENSORS & SENSOR_FAULT) != '0 |=> ERROR_LED; endproperty
  a_bad: assert property (p_bad) else $error("sensor fault not flagged");
  property p_en; SENSOR_ENABLE == (STORED_SENSORS & SENSOR_PRESENT & ~SENSOR_FAULT); endproperty
  a_en: assert property (p_en) else $error("channel blocking wrong");
  property p_lost; CE && (STORED_SENSORS & ~SENSOR_PRESENT) != '0 |=> !SYSTEM_FAIL_OUTPUT; endproperty
  a_lost: assert property (p_lost) else $error("missing sensor not flagged");
  property p_new; CE && (SENSOR_PRESENT & ~STORED_SENSORS) != '0 |=> ERROR_LED; endproperty
  a_new: assert property (p_new) else $error("new sensor not flagged");
  property p_sets; CE && SETTINGS_ALARM |=> !SYSTEM_FAIL_OUTPUT; endproperty
  a_sets: assert property (p_sets) else $error("settings alarm not on output");
  property p_clear; s_alarm_drop |-> $past(SET_BUTTON, 2) && $past(SET_BUTTON, 6); endproperty
  a_clear: assert property (p_clear) else $error("alarm cleared without hold");
  property p_open; OPEN_CT_ALARM == ((|above) && (|zero) && (&(above | zero))); endproperty
  a_open: assert property (p_open) else $error("open transformer alarm wrong");
endmodule
bind prss_top prss_top_assertions #(.NS(NS), .CW(CW)) u_chk (.CLOCK(CLOCK), .RSTN(RSTN),
  .CE(CE), .SUPPLY_OK(SUPPLY_OK), .HW_FAULT(HW_FAULT), .SW_FAULT(SW_FAULT),
  .SENSOR_PRESENT(SENSOR_PRESENT), .SENSOR_FAULT(SENSOR_FAULT), .SET_BUTTON(SET_BUTTON),
  .PHASE_CURRENT_A(PHASE_CURRENT_A), .PHASE_CURRENT_B(PHASE_CURRENT_B),
  .PHASE_CURRENT_C(PHASE_CURRENT_C), .NOMINAL_CURRENT(NOMINAL_CURRENT),
  .SYSTEM_FAIL_OUTPUT(SYSTEM_FAIL_OUTPUT), .ERROR_LED(ERROR_LED),
  .SENSOR_ENABLE(SENSOR_ENABLE), .STORED_SENSORS(STORED_SENSORS),
  .SETTINGS_ALARM(SETTINGS_ALARM), .OPEN_CT_ALARM(OPEN_CT_ALARM));

// *** test/prss_field.sv ***
// Field model: arc sensor channels and phase current transformers
module prss_field
  import prss_pkg::*;
(
  input wire logic [NUM_SENS-1:0] conn,
  input wire logic [NUM_SENS-1:0] bad,
  input wire logic [NUM_PH-1:0] ph_on,
  output logic [NUM_SENS-1:0] present,
  output logic [NUM_SENS-1:0] fault,
  output logic [CUR_W-1:0] cur_a,
  output logic [CUR_W-1:0] cur_b,
  output logic [CUR_W-1:0] cur_c,
  output logic [CUR_W-1:0] nominal
);
  timeunit 1ns;
  timeprecision 1ps;
  // Load well above 0.2 x nominal; an open secondary reads exactly zero
  localparam logic [CUR_W-1:0] LOAD = 16'h0030;
  assign present = conn;
  // An unplugged sensor cannot report its own fault
  assign fault = conn & bad;
  assign cur_a = ph_on[0] ? LOAD : CUR_ZERO;
  assign cur_b = ph_on[1] ? LOAD : CUR_ZERO;
  assign cur_c = ph_on[2] ? LOAD : CUR_ZERO;
  assign nominal = 16'h0064;
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the self-supervision core
module testbench
  import prss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int H = 20;
  localparam int B = 4;
  localparam int S = 8;
  logic clock, rstn, ce, supply_ok, hw_fault, sw_fault, set_button, fast_req;
  logic [3:0] conn, bad, present, fault, sensor_led, sensor_en, stored_sens, light;
  logic [2:0] ph_on, phase_led;
  logic [1:0] bin, stored_bin;
  logic [15:0] sw, active_sw, cur_a, cur_b, cur_c, nominal;
  logic sf_out, power_led, error_led, set_alarm, open_ct, energized, fast_two;
  int fail_count = 0;
  int n_compared = 0;
  prss_field u_field (.conn(conn), .bad(bad), .ph_on(ph_on), .present(present), .fault(fault),
    .cur_a(cur_a), .cur_b(cur_b), .cur_c(cur_c), .nominal(nominal));
  prss_top #(.HOLD(H), .BLINK(B), .SYNC_PERIOD(S)) DUT (.CLOCK(clock), .RSTN(rstn), .CE(ce),
    .SUPPLY_OK(supply_ok), .HW_FAULT(hw_fault), .SW_FAULT(sw_fault), .SENSOR_PRESENT(present),
    .SENSOR_FAULT(fault), .SENSOR_LIGHT(light), .BIN_CONNECTED(bin), .SWITCHES(sw),
    .SET_BUTTON(set_button), .PHASE_CURRENT_A(cur_a), .PHASE_CURRENT_B(cur_b),
    .PHASE_CURRENT_C(cur_c), .NOMINAL_CURRENT(nominal), .FAST_OUTPUT_TWO_REQ(fast_req),
    .SYSTEM_FAIL_OUTPUT(sf_out), .POWER_LED(power_led), .ERROR_LED(error_led),
    .SENSOR_LED(sensor_led), .PHASE_LED(phase_led), .SENSOR_ENABLE(sensor_en),
    .ACTIVE_SWITCHES(active_sw), .STORED_SENSORS(stored_sens), .STORED_BINARY(stored_bin),
    .SETTINGS_ALARM(set_alarm), .OPEN_CT_ALARM(open_ct), .ENERGIZED(energized),
    .FAST_OUTPUT_TWO(fast_two));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Ends mid-cycle so outputs are settled; caller steps before driving again
  task automatic health(input int n, input logic ok);
    step(n);
    @(negedge clock);
    chk(sf_out, ok);
    chk(error_led, !ok);
  endtask
  task automatic press(input int n);
    set_button <= 1'b1;
    step(n);
    set_button <= 1'b0;
  endtask
  // Any two blink periods hold exactly one period of lit cycles
  task automatic lit_cycles(input logic ph, input logic [3:0] lit, output int n);
    n = 0;
    repeat (2 * B) begin
      @(negedge clock);
      n += ph ? (phase_led === lit[2:0]) : (sensor_led === lit);
    end
  endtask
  task automatic fault_set(input int i, input logic on);
    case (i)
      0: supply_ok <= !on;
      1: hw_fault <= on;
      2: sw_fault <= on;
      3: bad <= on ? 4'h2 : 4'h0;
      4: conn <= on ? 4'h2 : 4'h3;
      5: conn <= on ? 4'h7 : 4'h3;
      6: bin <= on ? 2'h1 : 2'h3;
      7: ph_on <= on ? 3'h6 : 3'h7;
      default: ph_on <= on ? 3'h0 : 3'h7;
    endcase
  endtask
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int pulses;
    int n_lit;
    {rstn, set_button, fast_req, hw_fault, sw_fault} = 5'h00;
    {ce, supply_ok} = 2'h3;
    {conn, bad, ph_on, bin, sw} = {4'h3, 4'h0, 3'h7, 2'h3, 16'h00A5};
    light = 4'h1;
    step(16);
    rstn <= 1'b1;
    health(1, 1'b0);
    step(1);
    press(H + 3);
    health(3, 1'b1);
    chk(stored_sens, 16'h0003);
    chk(stored_bin, 16'h0003);
    chk(power_led, 16'h0001);
    chk(sensor_led, 16'h0001);
    for (int i = 0; i < 9; i++) begin
      step(1);
      fault_set(i, 1'b1);
      health(2, i == 8);
      if (i == 3) begin
        chk(sensor_en, 16'h0001);
        lit_cycles(1'b0, 4'h3, n_lit);
        chk(16'(n_lit), 16'(B));
      end
      if (i == 4) chk(sensor_en, 16'h0002);
      if (i == 5) begin
        lit_cycles(1'b0, 4'h5, n_lit);
        chk(16'(n_lit), 16'(B));
      end
      if (i == 7) begin
        chk({open_ct, energized}, 16'h0003);
        lit_cycles(1'b1, 4'h7, n_lit);
        chk(16'(n_lit), 16'(B));
      end
      if (i == 8) chk({open_ct, energized}, 16'h0000);
      step(1);
      fault_set(i, 1'b0);
      health(2, 1'b1);
    end
    step(1);
    sw <= 16'h00A4;
    health(2, 1'b0);
    chk(set_alarm, 16'h0001);
    chk(active_sw, 16'h00A5);
    step(1);
    sw <= 16'h00A5;
    press(5);
    health(3, 1'b0);
    step(1);
    press(H + 3);
    health(3, 1'b1);
    step(1);
    fast_req <= 1'b1;
    step(2);
    @(negedge clock);
    chk(fast_two, 16'h0001);
    @(posedge clock);
    fast_req <= 1'b0;
    step(1);
    pulses = 0;
    repeat (2 * S) begin
      @(negedge clock);
      pulses += (fast_two === 1'b1);
    end
    chk(16'(pulses), 16'h0002);
    summarize();
  end
endmodule
